/* File: host_access_model.sv */
// host_access_model: cpu or programmer memory triggers.
// assumes requests on the controller's clock.
`timescale 1ns/10ps
module host_access_model (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // bench requests
   input  wire logic        req,
   input  wire logic        rd_op,
   input  wire logic        rude,
   input  wire logic [15:0] adr,
   input  wire logic [15:0] wd,
   // controller side
   input  wire logic        busy_r,
   output logic             nvm_rd,
   output logic             nvm_wr,
   output logic [15:0]      nvm_addr,
   output logic [15:0]      nvm_wdata
);
   logic go;
   // hold off while busy, unless told to misbehave
   assign go = req & (~busy_r | rude);
   // one word or byte per access
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         nvm_rd <= 1'b0;
         nvm_wr <= 1'b0;
         nvm_addr <= 16'h0000;
         nvm_wdata <= 16'h0000;
      end else begin
         nvm_rd <= go & rd_op;
         nvm_wr <= go & ~rd_op;
         // idle lines toggle
         nvm_addr <= go ? adr : ~nvm_addr;
         nvm_wdata <= go ? wd : ~nvm_wdata;
      end
   end
endmodule

/* File: nvm_ctrl_monitor.sv */
// nvm_ctrl_monitor: port checks on the controller.
// assumes one clock and active-high reset.
`timescale 1ns/10ps
module nvm_ctrl_monitor (
   // clock and reset
   input wire logic                      ref_clk,
   input wire logic                      rst,
   // requests
   input wire logic                      ext_src,
   input wire logic                      change_protection_sequence,
   input wire logic                      cmd_wr,
   input wire logic [nvm_pkg::CMD_W-1:0] cmd_wdata,
   input wire logic                      control_a_register_wr,
   input wire logic                      execute_trigger_bit,
   input wire logic                      nvm_rd,
   input wire logic                      nvm_wr,
   // answers
   input wire logic [nvm_pkg::CMD_W-1:0] cmd_r,
   input wire logic                      busy_r,
   input wire logic                      refused_r,
   input wire logic [7:0]                lock_r,
   input wire logic                      rd_valid_r
);
   import nvm_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_CMD_TAKE: assert property (!busy_r && cmd_wr |=>
      cmd_r == $past(cmd_wdata)) else $error("cmd lost");
   AST_CMD_HOLD: assert property (busy_r && cmd_wr |=>
      $stable(cmd_r) && refused_r) else $error("busy write");
   AST_RD_ANS: assert property (!busy_r && nvm_rd |=>
      rd_valid_r) else $error("no read");
   AST_RD_BLK: assert property (busy_r && nvm_rd && ext_src |=>
      !rd_valid_r && refused_r) else $error("busy read");
   AST_NO_PROT: assert property (!busy_r && nvm_wr && !ext_src &&
      !change_protection_sequence && cmd_r == CMD_ER_FPG |=>
      !busy_r ##1 !busy_r) else $error("unprot erase");
   AST_WR_START: assert property (!busy_r && nvm_wr && ext_src &&
      cmd_r == CMD_WR_FPG |=> busy_r [*8]) else $error("no write");
   AST_EXEC: assert property (!busy_r && control_a_register_wr &&
      execute_trigger_bit && ext_src && cmd_r == CMD_EW_EPG |=> busy_r)
      else $error("no action");
   AST_LOAD_IDLE: assert property (!busy_r && nvm_wr &&
      cmd_r == CMD_LD_FBUF |=> !busy_r) else $error("load busy");
   AST_LOCK_UP: assert property ($changed(lock_r) |->
      $past(ext_src) || (lock_r & ~$past(lock_r)) == 8'h00)
      else $error("lock loosened");
   COV_BUSY: cover property ($rose(busy_r));
   COV_REF: cover property (refused_r);
   COV_RD: cover property (rd_valid_r);
endmodule

bind nvm_programming_controller nvm_ctrl_monitor nvm_ctrl_monitor_i (
   .ref_clk, .rst, .ext_src, .change_protection_sequence, .cmd_wr,
   .cmd_wdata, .control_a_register_wr, .execute_trigger_bit, .nvm_rd, .nvm_wr,
   .cmd_r, .busy_r, .refused_r, .lock_r, .rd_valid_r);

/* File: nvm_pkg.sv */
// nvm_pkg: shared constants for the nonvolatile memory programming
// controller and its page buffers.
// assumes a single 25 MHz system clock and one asynchronous reset.
package nvm_pkg;

   // clock rate and operation times
   localparam int CLK_MHZ       = 25;
   localparam int ERASE_TIME_NS = 20000;
   localparam int WRITE_TIME_NS = 20000;
   localparam int TIMER_W       = 12;
   // least times, rounded up to whole cycles
   localparam logic [TIMER_W-1:0] ERASE_CYC =
      TIMER_W'((ERASE_TIME_NS * CLK_MHZ + 999) / 1000);
   localparam logic [TIMER_W-1:0] WRITE_CYC =
      TIMER_W'((WRITE_TIME_NS * CLK_MHZ + 999) / 1000);

   // widths and erased values
   localparam int CMD_W = 7;
   localparam int ADR_W = 16;
   localparam logic [15:0] FLASH_ERASED = 16'hFFFF;
   localparam logic [7:0]  EE_ERASED    = 8'hFF;

   // reset values
   localparam logic [CMD_W-1:0] CMD_RESET   = 7'h00;
   localparam logic [7:0]       CTRLB_RESET = 8'h00;
   localparam logic [7:0]       LOCK_RESET  = 8'hFF;
   localparam logic [7:0]       FUSE_RESET  = 8'hFF;
   localparam logic [15:0]      CHK_SEED    = 16'h0000;

   // command codes: read triggered
   localparam logic [CMD_W-1:0] CMD_NOP     = 7'h00;
   localparam logic [CMD_W-1:0] CMD_RD_USIG = 7'h01;
   localparam logic [CMD_W-1:0] CMD_RD_CAL  = 7'h02;
   localparam logic [CMD_W-1:0] CMD_RD_EE   = 7'h06;
   // command codes: write triggered
   localparam logic [CMD_W-1:0] CMD_LD_FBUF = 7'h23;
   localparam logic [CMD_W-1:0] CMD_ER_FPG  = 7'h2B;
   localparam logic [CMD_W-1:0] CMD_WR_FPG  = 7'h2E;
   localparam logic [CMD_W-1:0] CMD_EW_FPG  = 7'h2F;
   localparam logic [CMD_W-1:0] CMD_WR_USIG = 7'h18;
   localparam logic [CMD_W-1:0] CMD_LD_EBUF = 7'h33;
   // command codes: action triggered
   localparam logic [CMD_W-1:0] CMD_ER_FBUF = 7'h26;
   localparam logic [CMD_W-1:0] CMD_ER_EBUF = 7'h36;
   localparam logic [CMD_W-1:0] CMD_ER_EPG  = 7'h32;
   localparam logic [CMD_W-1:0] CMD_WR_EPG  = 7'h34;
   localparam logic [CMD_W-1:0] CMD_EW_EPG  = 7'h35;
   localparam logic [CMD_W-1:0] CMD_WR_LOCK = 7'h08;
   localparam logic [CMD_W-1:0] CMD_WR_FUSE = 7'h4C;
   localparam logic [CMD_W-1:0] CMD_CHK     = 7'h78;

endpackage

/* File: nvm_programming_controller.sv */
// nvm_programming_controller: command sequencer for flash, user
// signature row, EEPROM, lock and fuse bytes, with page buffers.
// assumes the cpu and the program_debug_link arbiter present one
// access at a time on the same clock, qualified by ext_src.
`timescale 1ns/10ps

// Summary of operation
// - execute bit write starts action commands
// - memory read starts read-class command
// - memory write starts write-class command
// - self-programming triggers need change protection, except reads and buffer loads
// - busy set; register writes ignored meanwhile
// - programming blocks loads, reads but cpu boot-page reads during app programming, other programming
// - flash buffer loads one word each
// - buffer load ANDs old and new
// - unloaded flash locations read and program ones
// - flash buffer erased on reset, writes, lock
// - EEPROM buffer loads one byte each
// - loaded EEPROM locations tagged until erase
// - EEPROM page ops touch tagged bytes only
// - EEPROM buffer erased on reset, writes, lock, fuse
// - separate erase, write and atomic erase-write
// - flash by page, EEPROM by byte or page
// - external port writes all but calibration row
// - self-programming only tightens lock bits
module nvm_programming_controller #(
   parameter int          FLASH_PAGES      = 16,
   parameter int          FLASH_PAGE_WORDS = 32,
   parameter int          EE_PAGES         = 8,
   parameter int          EE_PAGE_BYTES    = 32,
   parameter int          BOOT_START_PAGE  = 12,
   parameter logic [15:0] CAL_WORD         = 16'h5A3C
) (
   // clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rst,
   // access qualifiers
   input  wire logic                       ext_src,
   input  wire logic                       change_protection_sequence,
   // register writes
   input  wire logic                       cmd_wr,
   input  wire logic [nvm_pkg::CMD_W-1:0]  cmd_wdata,
   input  wire logic                       control_a_register_wr,
   input  wire logic                       execute_trigger_bit,
   input  wire logic                       ctrlb_wr,
   input  wire logic [7:0]                 ctrlb_wdata,
   input  wire logic                       addr_wr,
   input  wire logic [nvm_pkg::ADR_W-1:0]  addr_wdata,
   input  wire logic                       data_wr,
   input  wire logic [15:0]                data_wdata,
   // memory access triggers
   input  wire logic                       nvm_rd,
   input  wire logic                       nvm_wr,
   input  wire logic [nvm_pkg::ADR_W-1:0]  nvm_addr,
   input  wire logic [15:0]                nvm_wdata,
   // register readback
   output logic [nvm_pkg::CMD_W-1:0]       cmd_r,
   output logic [7:0]                      ctrlb_r,
   output logic [nvm_pkg::ADR_W-1:0]       addr_r,
   output logic [15:0]                     data_r,
   // status
   output logic                            busy_r,
   output logic                            prog_app_r,
   output logic                            refused_r,
   output logic [7:0]                      lock_r,
   output logic [7:0]                      fuse_r,
   output logic [15:0]                     checksum_r,
   // read answer
   output logic                            rd_valid_r,
   output logic [15:0]                     rd_data_r
);

   import nvm_pkg::*;

   localparam int FW_W  = $clog2(FLASH_PAGE_WORDS);
   localparam int FA_W  = FW_W + $clog2(FLASH_PAGES);
   localparam int PG_W  = FA_W - FW_W;
   localparam int EW_W  = $clog2(EE_PAGE_BYTES);
   localparam int EA_W  = EW_W + $clog2(EE_PAGES);
   localparam int IDX_W = (FA_W > EW_W) ? FA_W : EW_W;
   localparam int FTOT  = FLASH_PAGES * FLASH_PAGE_WORDS;
   localparam int ETOT  = EE_PAGES * EE_PAGE_BYTES;

   typedef enum {S_IDLE, S_SWEEP, S_WAIT, S_CHK} state_t;
   typedef enum {K_ER, K_WR, K_EW} kind_t;
   typedef enum {T_FLASH, T_USIG, T_EE, T_LOCK, T_FUSE, T_CHK} tgt_t;

   // the arrays themselves; contents survive reset
   logic [15:0] flash_mem [FTOT];
   logic [15:0] usig_mem  [FLASH_PAGE_WORDS];
   logic [7:0]  ee_mem    [ETOT];

   state_t               state_r;
   kind_t                kind_r;
   tgt_t                 tgt_r;
   logic [IDX_W-1:0]     idx_r;
   logic [TIMER_W-1:0]   tmr_r;
   logic [ADR_W-1:0]     op_addr_r;

   logic                 prot_ok;
   logic                 rww_ok;
   logic                 act_go;
   logic                 rd_go;
   logic                 wr_go;
   logic                 fin;
   logic                 refuse_nxt;
   logic                 start;
   kind_t                st_kind;
   tgt_t                 st_tgt;
   logic [ADR_W-1:0]     st_addr;
   logic                 fbuf_ld;
   logic                 ebuf_ld;
   logic                 fbuf_ers;
   logic                 ebuf_ers;
   logic                 fbuf_clr;
   logic                 ebuf_clr;
   logic [15:0]          fbuf_q;
   logic [7:0]           ebuf_q;
   logic                 ebuf_tag;
   logic [IDX_W-1:0]     last_idx;
   logic [FA_W-1:0]      f_idx;
   logic [EA_W-1:0]      e_idx;
   logic [15:0]          f_new;
   logic [15:0]          u_new;
   logic [15:0]          e_new;
   logic [15:0]          rd_word;
   logic [PG_W-1:0]      rd_page;
   logic [PG_W-1:0]      st_page;

   function automatic logic is_prot(input logic [CMD_W-1:0] c);
      is_prot = !(c == CMD_LD_FBUF || c == CMD_LD_EBUF);
   endfunction

   // program merge: erase gives ones, write can only clear bits
   function automatic logic [15:0] merge(input kind_t k,
                                         input logic [15:0] old,
                                         input logic [15:0] nb);
      case (k)
         K_ER:    merge = FLASH_ERASED;
         K_WR:    merge = old & nb;
         default: merge = nb;
      endcase
   endfunction

   assign prot_ok = ext_src | change_protection_sequence;
   assign rd_page = nvm_addr[FA_W-1:FW_W];
   assign st_page = st_addr[FA_W-1:FW_W];
   // cpu may read boot pages during app programming
   assign rww_ok  = !ext_src && prog_app_r &&
                    (rd_page >= PG_W'(BOOT_START_PAGE));

   assign act_go = control_a_register_wr && execute_trigger_bit && !busy_r &&
                   prot_ok;
   assign rd_go  = nvm_rd && (!busy_r || rww_ok);
   // write trigger, protected ones need the sequence
   assign wr_go  = nvm_wr && !busy_r && (prot_ok || !is_prot(cmd_r));

   always_comb begin
      refuse_nxt = 1'b0;
      if (busy_r && (cmd_wr || control_a_register_wr || ctrlb_wr || addr_wr ||
                     data_wr || nvm_wr))
         refuse_nxt = 1'b1;
      if (nvm_rd && !rd_go)
         refuse_nxt = 1'b1;
      if (!busy_r && !prot_ok && control_a_register_wr && execute_trigger_bit)
         refuse_nxt = 1'b1;
      if (!busy_r && !prot_ok && nvm_wr && is_prot(cmd_r))
         refuse_nxt = 1'b1;
      // fuse bytes are writable from the external port only
      if (act_go && cmd_r == CMD_WR_FUSE && !ext_src)
         refuse_nxt = 1'b1;
   end

   // command decode for both trigger kinds
   always_comb begin
      fbuf_ld  = 1'b0;
      ebuf_ld  = 1'b0;
      fbuf_ers = 1'b0;
      ebuf_ers = 1'b0;
      start    = 1'b0;
      st_kind  = K_WR;
      st_tgt   = T_FLASH;
      st_addr  = wr_go ? nvm_addr : addr_r;
      if (wr_go) begin
         case (cmd_r)
            // one word per flash buffer load
            CMD_LD_FBUF: fbuf_ld = 1'b1;
            // one byte per EEPROM buffer load
            CMD_LD_EBUF: ebuf_ld = 1'b1;
            // split and atomic flash page commands
            CMD_ER_FPG: begin
               start   = 1'b1;
               st_kind = K_ER;
            end
            CMD_WR_FPG: begin
               start   = 1'b1;
               st_kind = K_WR;
            end
            CMD_EW_FPG: begin
               start   = 1'b1;
               st_kind = K_EW;
            end
            CMD_WR_USIG: begin
               start   = 1'b1;
               st_kind = K_EW;
               st_tgt  = T_USIG;
            end
            default: ;
         endcase
      end else if (act_go) begin
         case (cmd_r)
            CMD_ER_FBUF: fbuf_ers = 1'b1;
            CMD_ER_EBUF: ebuf_ers = 1'b1;
            // EEPROM page ops, a single tag makes a byte update
            CMD_ER_EPG: begin
               start   = 1'b1;
               st_kind = K_ER;
               st_tgt  = T_EE;
            end
            CMD_WR_EPG: begin
               start   = 1'b1;
               st_kind = K_WR;
               st_tgt  = T_EE;
            end
            CMD_EW_EPG: begin
               start   = 1'b1;
               st_kind = K_EW;
               st_tgt  = T_EE;
            end
            CMD_WR_LOCK: begin
               start   = 1'b1;
               st_tgt  = T_LOCK;
            end
            CMD_WR_FUSE: begin
               start   = ext_src;
               st_tgt  = T_FUSE;
            end
            CMD_CHK: begin
               start   = 1'b1;
               st_tgt  = T_CHK;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmd_r   <= CMD_RESET;
         ctrlb_r <= CTRLB_RESET;
         addr_r  <= '0;
         data_r  <= '0;
      end else if (!busy_r) begin
         if (cmd_wr)
            cmd_r <= cmd_wdata;
         if (ctrlb_wr)
            ctrlb_r <= ctrlb_wdata;
         if (addr_wr)
            addr_r <= addr_wdata;
         if (data_wr)
            data_r <= data_wdata;
      end
   end

   assign last_idx = (tgt_r == T_EE) ? IDX_W'(EE_PAGE_BYTES - 1) :
                     (tgt_r == T_CHK) ? IDX_W'(FTOT - 1) :
                     IDX_W'(FLASH_PAGE_WORDS - 1);
   assign fin = (state_r == S_WAIT) && (tmr_r == TIMER_W'(1));

   // operation sequencer
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r    <= S_IDLE;
         busy_r     <= 1'b0;
         prog_app_r <= 1'b0;
         kind_r     <= K_WR;
         tgt_r      <= T_FLASH;
         idx_r      <= '0;
         tmr_r      <= '0;
         op_addr_r  <= '0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (start) begin
                  busy_r    <= 1'b1;
                  kind_r    <= st_kind;
                  tgt_r     <= st_tgt;
                  idx_r     <= '0;
                  op_addr_r <= st_addr;
                  prog_app_r <= (st_tgt == T_FLASH) &&
                                (st_page < PG_W'(BOOT_START_PAGE));
                  if (st_tgt == T_CHK)
                     state_r <= S_CHK;
                  else if (st_tgt == T_LOCK || st_tgt == T_FUSE) begin
                     tmr_r   <= WRITE_CYC;
                     state_r <= S_WAIT;
                  end else
                     state_r <= S_SWEEP;
               end
            end
            S_SWEEP: begin
               idx_r <= idx_r + IDX_W'(1);
               if (idx_r == last_idx) begin
                  case (kind_r)
                     K_ER:    tmr_r <= ERASE_CYC;
                     K_WR:    tmr_r <= WRITE_CYC;
                     default: tmr_r <= ERASE_CYC + WRITE_CYC;
                  endcase
                  state_r <= S_WAIT;
               end
            end
            S_WAIT: begin
               tmr_r <= tmr_r - TIMER_W'(1);
               // release on the edge after the last cycle
               if (fin) begin
                  busy_r     <= 1'b0;
                  prog_app_r <= 1'b0;
                  state_r    <= S_IDLE;
               end
            end
            S_CHK: begin
               idx_r <= idx_r + IDX_W'(1);
               if (idx_r == last_idx) begin
                  busy_r  <= 1'b0;
                  state_r <= S_IDLE;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // flash buffer erase after writes and lock
   assign fbuf_clr = fbuf_ers || (fin && (tgt_r == T_LOCK ||
                     ((tgt_r == T_FLASH || tgt_r == T_USIG) &&
                      kind_r != K_ER)));
   // EEPROM buffer erase after writes, lock, fuse
   assign ebuf_clr = ebuf_ers || (fin && (tgt_r == T_LOCK ||
                     tgt_r == T_FUSE ||
                     (tgt_r == T_EE && kind_r != K_ER)));

   page_buffer #(
      .DW     (16),
      .DEPTH  (FLASH_PAGE_WORDS),
      .IW     (FW_W),
      .ERASED (FLASH_ERASED)
   ) u_fbuf (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clr     (fbuf_clr),
      .ld      (fbuf_ld),
      .ld_idx  (nvm_addr[FW_W-1:0]),
      .ld_data (nvm_wdata),
      .rd_idx  (idx_r[FW_W-1:0]),
      .rd_data (fbuf_q),
      .rd_tag  ()
   );

   page_buffer #(
      .DW     (8),
      .DEPTH  (EE_PAGE_BYTES),
      .IW     (EW_W),
      .ERASED (EE_ERASED)
   ) u_ebuf (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clr     (ebuf_clr),
      .ld      (ebuf_ld),
      .ld_idx  (nvm_addr[EW_W-1:0]),
      .ld_data (nvm_wdata[7:0]),
      .rd_idx  (idx_r[EW_W-1:0]),
      .rd_data (ebuf_q),
      .rd_tag  (ebuf_tag)
   );

   assign f_idx = {op_addr_r[FA_W-1:FW_W], idx_r[FW_W-1:0]};
   assign e_idx = {op_addr_r[EA_W-1:EW_W], idx_r[EW_W-1:0]};
   assign f_new = merge(kind_r, flash_mem[f_idx], fbuf_q);
   assign u_new = merge(kind_r, usig_mem[idx_r[FW_W-1:0]], fbuf_q);
   assign e_new = merge(kind_r, {8'h00, ee_mem[e_idx]},
                        {8'h00, ebuf_q});

   // flash is swept a whole page at a time
   always_ff @(posedge ref_clk) begin
      if (state_r == S_SWEEP) begin
         case (tgt_r)
            T_FLASH: flash_mem[f_idx] <= f_new;
            T_USIG:  usig_mem[idx_r[FW_W-1:0]] <= u_new;
            T_EE: begin
               if (ebuf_tag)
                  ee_mem[e_idx] <= e_new[7:0];
            end
            default: ;
         endcase
      end
   end

   // lock and fuse bytes take effect at the trigger
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lock_r <= LOCK_RESET;
         fuse_r <= FUSE_RESET;
      end else if (state_r == S_IDLE && start) begin
         // cpu can only clear lock bits
         if (st_tgt == T_LOCK)
            lock_r <= ext_src ? data_r[7:0] : (lock_r & data_r[7:0]);
         if (st_tgt == T_FUSE)
            fuse_r <= data_r[7:0];
      end
   end

   // rotate-xor signature over the whole flash
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         checksum_r <= CHK_SEED;
      else if (state_r == S_IDLE && start && st_tgt == T_CHK)
         checksum_r <= CHK_SEED;
      else if (state_r == S_CHK)
         checksum_r <= {checksum_r[14:0], checksum_r[15]} ^
                       flash_mem[idx_r[FA_W-1:0]];
   end

   always_comb begin
      rd_word = flash_mem[nvm_addr[FA_W-1:0]];
      // a read-while-write read is always a plain flash read
      if (!busy_r) begin
         case (cmd_r)
            CMD_RD_USIG: rd_word = usig_mem[nvm_addr[FW_W-1:0]];
            CMD_RD_CAL:  rd_word = CAL_WORD;
            CMD_RD_EE:   rd_word = {8'h00, ee_mem[nvm_addr[EA_W-1:0]]};
            default:     ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_valid_r <= 1'b0;
         rd_data_r  <= '0;
         refused_r  <= 1'b0;
      end else begin
         rd_valid_r <= rd_go;
         refused_r  <= refuse_nxt;
         if (rd_go)
            rd_data_r <= rd_word;
      end
   end

endmodule

/* File: page_buffer.sv */
// page_buffer: one page of AND-loaded storage with a tag per location.
// assumes loads and clears come from logic on the same clock.
`timescale 1ns/10ps

module page_buffer #(
   parameter int             DW     = 16,
   parameter int             DEPTH  = 32,
   parameter int             IW     = $clog2(DEPTH),
   parameter logic [DW-1:0]  ERASED = '1
) (
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst,
   // erase and load
   input  wire logic          clr,
   input  wire logic          ld,
   input  wire logic [IW-1:0] ld_idx,
   input  wire logic [DW-1:0] ld_data,
   // sweep read
   input  wire logic [IW-1:0] rd_idx,
   output logic      [DW-1:0] rd_data,
   output logic               rd_tag
);

   logic [DW-1:0] data_r [DEPTH];
   logic          tag_r  [DEPTH];

   genvar i;
   for (i = 0; i < DEPTH; i = i + 1) begin : g_loc
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            data_r[i] <= ERASED;
            tag_r[i]  <= 1'b0;
         // clear wins over a load in the same cycle
         end else if (clr) begin
            data_r[i] <= ERASED;
            tag_r[i]  <= 1'b0;
         end else if (ld && ld_idx == IW'(i)) begin
            data_r[i] <= data_r[i] & ld_data;
            tag_r[i]  <= 1'b1;
         end
      end
   end

   assign rd_data = data_r[rd_idx];
   assign rd_tag  = tag_r[rd_idx];

endmodule

/* File: tb_nvm_programming_controller.sv */
// tb_nvm_programming_controller: self-checking bench.
// assumes the package compiles first.
`timescale 1ns/10ps
module tb_nvm_programming_controller;
   import nvm_pkg::*;
   localparam int FW = 32;
   logic ref_clk = 1'b0, rst = 1'b1, ext_src = 1'b1;
   logic change_protection_sequence = 1'b0;
   logic cmd_wr = 1'b0, control_a_register_wr = 1'b0, execute_trigger_bit = 1'b0;
   logic ctrlb_wr = 1'b0, addr_wr = 1'b0, data_wr = 1'b0;
   logic [CMD_W-1:0] cmd_wdata = 7'h00, cmd_r;
   logic [7:0] ctrlb_wdata = 8'h00, ctrlb_r, lock_r, fuse_r, x1, y1, x2;
   logic [15:0] addr_wdata = 16'h0000, data_wdata = 16'h0000;
   logic req = 1'b0, rd_op = 1'b0, rude = 1'b0, nvm_rd, nvm_wr;
   logic [15:0] adr = 16'h0000, wd = 16'h0000, nvm_addr, nvm_wdata;
   logic [15:0] addr_r, data_r, checksum_r, rd_data_r, base, va, vb, vc, eb;
   logic busy_r, prog_app_r, refused_r, rd_valid_r;
   int num_errors = 0, cmp_count = 0, n, seed;
   nvm_programming_controller #(.FLASH_PAGE_WORDS(FW))
      nvm_programming_controller_i (.*);
   host_access_model host_access_model_i (.*);
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   task chk(input logic [15:0] g, e, input string m);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask
   task wreg(input int k, input logic [15:0] v);
      @(posedge ref_clk);
      cmd_wdata <= v[CMD_W-1:0];
      addr_wdata <= v;
      data_wdata <= v;
      ctrlb_wdata <= v[7:0];
      {cmd_wr, addr_wr, data_wr, ctrlb_wr} <= 4'h8 >> k;
      @(posedge ref_clk);
      {cmd_wr, addr_wr, data_wr, ctrlb_wr} <= 4'h0;
   endtask
   task exec;
      @(posedge ref_clk);
      control_a_register_wr <= 1'b1;
      execute_trigger_bit <= 1'b1;
      @(posedge ref_clk);
      control_a_register_wr <= 1'b0;
      execute_trigger_bit <= 1'b0;
   endtask
   task acc(input logic r, ru, input logic [15:0] a, d);
      @(posedge ref_clk);
      req <= 1'b1;
      rd_op <= r;
      rude <= ru;
      adr <= a;
      wd <= d;
      @(posedge ref_clk);
      req <= 1'b0;
      rude <= 1'b0;
      @(posedge ref_clk);
   endtask
   task rd(input logic [15:0] a, e);
      acc(1'b1, 1'b0, a, 16'h0000);
      @(negedge ref_clk);
      chk(rd_valid_r, 1'b1, "no read");
      chk(rd_data_r, e, "read data");
   endtask
   task wait_idle;
      n = 0;
      @(negedge ref_clk);
      while (busy_r === 1'b1 && n < 5000) begin
         n++;
         @(negedge ref_clk);
      end
   endtask
   task final_report;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge ref_clk);
      num_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      final_report;
   end
   initial begin
      seed = 32'h6371;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      chk(busy_r, 1'b0, "busy rst");
      chk(lock_r, LOCK_RESET, "lock rst");
      base = 16'(($random(seed) & 15) << 5);
      va = $random(seed);
      vb = $random(seed);
      vc = $random(seed);
      eb = $random(seed);
      wreg(3, eb);
      @(negedge ref_clk);
      chk(ctrlb_r, eb[7:0], "ctrlb");
      wreg(0, CMD_ER_FPG);
      acc(1'b0, 1'b0, base, 16'h0000);
      wait_idle;
      chk(16'(n), 16'(FW) + ERASE_CYC, "erase time");
      wreg(0, CMD_LD_FBUF);
      acc(1'b0, 1'b0, base + 3, va);
      acc(1'b0, 1'b0, base + 3, vb);
      wreg(0, CMD_WR_FPG);
      acc(1'b0, 1'b0, base, 16'h0000);
      wait_idle;
      chk(16'(n), 16'(FW) + WRITE_CYC, "write time");
      wreg(0, CMD_NOP);
      rd(base + 3, va & vb);
      rd(base + 7, FLASH_ERASED);
      wreg(0, CMD_LD_FBUF);
      acc(1'b0, 1'b0, base + 3, vc);
      wreg(0, CMD_EW_FPG);
      acc(1'b0, 1'b0, base, 16'h0000);
      wreg(0, CMD_LD_EBUF);
      @(negedge ref_clk);
      chk(cmd_r, CMD_EW_FPG, "cmd busy");
      chk(refused_r, 1'b1, "no refusal");
      acc(1'b1, 1'b1, base, 16'h0000);
      @(negedge ref_clk);
      chk(rd_valid_r, 1'b0, "rd busy");
      wait_idle;
      wreg(0, CMD_NOP);
      rd(base + 3, vc);
      @(posedge ref_clk) ext_src <= 1'b0;
      wreg(0, CMD_ER_FPG);
      acc(1'b0, 1'b0, base, 16'h0000);
      @(negedge ref_clk);
      chk(busy_r, 1'b0, "unprot erase");
      @(posedge ref_clk) ext_src <= 1'b1;
      eb = 16'(($random(seed) & 7) << 5);
      {x1, y1, x2} = 24'($random(seed));
      wreg(1, eb);
      wreg(0, CMD_LD_EBUF);
      acc(1'b0, 1'b0, eb, {8'h00, x1});
      acc(1'b0, 1'b0, eb + 1, {8'h00, y1});
      wreg(0, CMD_EW_EPG);
      exec;
      wait_idle;
      wreg(0, CMD_LD_EBUF);
      acc(1'b0, 1'b0, eb, {8'h00, x2});
      wreg(0, CMD_EW_EPG);
      exec;
      wait_idle;
      wreg(0, CMD_RD_EE);
      rd(eb, {8'h00, x2});
      rd(eb + 1, {8'h00, y1});
      wreg(2, 16'h000F);
      wreg(0, CMD_WR_LOCK);
      @(posedge ref_clk) ext_src <= 1'b0;
      change_protection_sequence <= 1'b1;
      exec;
      @(negedge ref_clk);
      chk(lock_r, 8'h0F, "cpu lock");
      wait_idle;
      wreg(2, 16'h00F0);
      exec;
      wait_idle;
      chk(lock_r, 8'h00, "lock tighten");
      wreg(0, CMD_WR_FUSE);
      wreg(2, 16'h005A);
      exec;
      @(negedge ref_clk);
      chk(fuse_r, FUSE_RESET, "cpu fuse");
      @(posedge ref_clk) ext_src <= 1'b1;
      exec;
      wait_idle;
      chk(fuse_r, 8'h5A, "ext fuse");
      final_report;
   end
endmodule
